// ===== dsr_core_regs.sv
// core control register bank: bus address, back channel, soft resets, output overrides
// assumes the bus target front end hands over decoded one-cycle register accesses
// and that pass-through bits and lock come from logic on the same clock
`timescale 1ns/1ps
// Operation
// - address bits 7..1 hold own bus address, defaulting to strap value.
// - bit 0 picks strap address (0) or written address (1).
// - back channel bit resets to 1; remote writes cannot clear it.
// - back channel stops only if its bit and both pass-through bits are low.
// - writing 1 to bit 1 resets the whole logic including registers.
// - on full soft reset the strap address keeps its first sampled value; the strap is not sampled again.
// - writing 1 to bit 0 resets logic but keeps registers; self-clears.
// - soft resets leave address register and reset bits 4:3, 1:0 untouched.
// - bit 7 is output enable override value; without override enable is 1.
// - bit 6 makes bits 7 and 4 replace their defaults.
// - bit 5 with lock lost routes the oscillator clock to pixel clock.
// - bit 4 is idle state override value; without override it is 1.
// - no field is latched or read-to-clear; reads have no side effect.
module dsr_core_regs (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [6:0] address_strap_pin_i,
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic remote_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic pass_through_a_i,
   input wire logic pass_through_b_i,
   input wire logic lock_i,
   output logic [7:0] rdata_o,
   output logic ack_o,
   output logic [6:0] own_bus_address_o,
   output logic return_channel_active_o,
   output logic soft_reset_o,
   output logic output_enable_o,
   output logic idle_state_choice_o,
   output logic fallback_clock_sel_o
);
   import dsr_pkg::*;

   dsr_rst_if rst ();

   logic [6:0] strap_s1_reg;
   logic [6:0] strap_s2_reg;
   logic [1:0] strap_vld_reg;
   logic [1:0] strap_vld_next;
   logic strap_done_reg;
   logic strap_done_next;
   logic [6:0] strap_orig_reg;
   logic [6:0] strap_orig_next;
   logic [6:0] addr_reg;
   logic [6:0] addr_next;
   logic src_sel_reg;
   logic src_sel_next;
   logic rc_on_reg;
   logic rc_on_next;
   logic [3:0] cfg_reg;
   logic [3:0] cfg_next;
   logic start_full_reg;
   logic start_full_next;
   logic start_logic_reg;
   logic start_logic_next;
   logic [7:0] rdata_next;
   logic [6:0] own_addr_next;
   logic rc_act_next;
   logic soft_rst_next;
   logic oe_next;
   logic idle_next;
   logic fb_next;
   logic wr_addr;
   logic wr_rst;
   logic wr_cfg;
   logic seq_idle;

   dsr_rst_seq u_seq (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .rst(rst.seq)
   );

   assign rst.start_full = start_full_reg;
   assign rst.start_logic = start_logic_reg;

   // write strobes per register
   assign wr_addr = req_i && wr_i && (addr_i == ADDR_BUS_ADDRESS_SELECT);
   assign wr_rst = req_i && wr_i && (addr_i == ADDR_RESET_AND_BACKCHANNEL);
   assign wr_cfg = req_i && wr_i && (addr_i == ADDR_OUTPUT_OVERRIDE_CONFIG);
   assign seq_idle = !rst.full_active && !rst.logic_active && !start_full_reg && !start_logic_reg;

   // strap synchroniser, only the second stage is read
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_s1_reg <= 7'h00;
         strap_s2_reg <= 7'h00;
      end else begin
         strap_s1_reg <= address_strap_pin_i;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // register next values
   always_comb begin
      strap_vld_next = {strap_vld_reg[0], 1'b1};
      strap_done_next = strap_done_reg;
      strap_orig_next = strap_orig_reg;
      addr_next = addr_reg;
      src_sel_next = src_sel_reg;
      rc_on_next = rc_on_reg;
      cfg_next = cfg_reg;
      start_full_next = 1'b0;
      start_logic_next = 1'b0;
      // strap caught once after release, never again by soft resets
      if (strap_vld_reg[1] && !strap_done_reg) begin
         strap_done_next = 1'b1;
         strap_orig_next = strap_s2_reg;
         addr_next = strap_s2_reg;
      end else if (wr_addr) begin
         // soft resets never touch this register
         addr_next = wdata_i[ADDR_MSB:ADDR_LSB];
         src_sel_next = wdata_i[ADDR_SRC_BIT];
      end
      // back channel bit
      if (rst.full_active) begin
         rc_on_next = RC_ON_RST;
      end else if (wr_rst) begin
         if (remote_i) begin
            rc_on_next = rc_on_reg | wdata_i[RC_ON_BIT];
         end else begin
            rc_on_next = wdata_i[RC_ON_BIT];
         end
      end
      // self-clearing triggers, accepted while the sequencer is idle
      if (wr_rst && seq_idle) begin
         start_full_next = wdata_i[FULL_RST_BIT];
         start_logic_next = wdata_i[LOGIC_RST_BIT];
      end
      // override config: full reset clears it, logic-only reset keeps it
      if (rst.full_active) begin
         cfg_next = CFG_RST;
      end else if (wr_cfg) begin
         cfg_next = wdata_i[OE_VAL_BIT:CFG_LSB];
      end
   end

   // read mux: plain fields only, reads have no side effect here
   always_comb begin
      rdata_next = RDATA_NONE;
      if (req_i && !wr_i) begin
         case (addr_i)
            ADDR_BUS_ADDRESS_SELECT: begin
               rdata_next = {addr_reg, src_sel_reg};
            end
            ADDR_RESET_AND_BACKCHANNEL: begin
               rdata_next[RC_ON_BIT] = rc_on_reg;
               rdata_next[FULL_RST_BIT] = start_full_reg | rst.full_active;
               rdata_next[LOGIC_RST_BIT] = start_logic_reg | rst.logic_active;
            end
            ADDR_OUTPUT_OVERRIDE_CONFIG: begin
               rdata_next = {cfg_reg, 4'h0};
            end
            default: begin
               rdata_next = RDATA_NONE;
            end
         endcase
      end
   end

   // output next values
   always_comb begin
      own_addr_next = src_sel_reg ? addr_reg : strap_orig_reg;
      rc_act_next = rc_on_reg | pass_through_a_i | pass_through_b_i;
      soft_rst_next = rst.full_active | rst.logic_active;
      oe_next = cfg_reg[OVR_BIT - CFG_LSB] ? cfg_reg[OE_VAL_BIT - CFG_LSB] : OVR_DEFAULT;
      idle_next = cfg_reg[OVR_BIT - CFG_LSB] ? cfg_reg[IDLE_BIT - CFG_LSB] : OVR_DEFAULT;
      fb_next = cfg_reg[FALLBACK_BIT - CFG_LSB] && !lock_i;
   end

   // registers and outputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_vld_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_orig_reg <= 7'h00;
         addr_reg <= 7'h00;
         src_sel_reg <= ADDR_SRC_RST;
         rc_on_reg <= RC_ON_RST;
         cfg_reg <= CFG_RST;
         start_full_reg <= 1'b0;
         start_logic_reg <= 1'b0;
         rdata_o <= RDATA_NONE;
         ack_o <= 1'b0;
         own_bus_address_o <= 7'h00;
         return_channel_active_o <= RC_ON_RST;
         soft_reset_o <= 1'b0;
         output_enable_o <= OVR_DEFAULT;
         idle_state_choice_o <= OVR_DEFAULT;
         fallback_clock_sel_o <= 1'b0;
      end else begin
         strap_vld_reg <= strap_vld_next;
         strap_done_reg <= strap_done_next;
         strap_orig_reg <= strap_orig_next;
         addr_reg <= addr_next;
         src_sel_reg <= src_sel_next;
         rc_on_reg <= rc_on_next;
         cfg_reg <= cfg_next;
         start_full_reg <= start_full_next;
         start_logic_reg <= start_logic_next;
         rdata_o <= rdata_next;
         ack_o <= req_i;
         own_bus_address_o <= own_addr_next;
         return_channel_active_o <= rc_act_next;
         soft_reset_o <= soft_rst_next;
         output_enable_o <= oe_next;
         idle_state_choice_o <= idle_next;
         fallback_clock_sel_o <= fb_next;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   strap_load_a: assert property ($rose(strap_done_reg) |-> addr_reg == strap_orig_reg)
      else $error("strap address not loaded");
   addr_src_a: assert property (!src_sel_reg && strap_done_reg && $stable(src_sel_reg)
      |=> own_bus_address_o == $past(strap_orig_reg))
      else $error("strap address not used");
   remote_clr_a: assert property (wr_rst && remote_i && !wdata_i[RC_ON_BIT]
      && rc_on_reg && !rst.full_active |=> rc_on_reg)
      else $error("remote write cleared back channel");
   rc_gate_a: assert property (!rc_on_reg && !pass_through_a_i && !pass_through_b_i
      |=> !return_channel_active_o)
      else $error("back channel active while disabled");
   full_cfg_a: assert property (start_full_reg |=> ##2 cfg_reg == CFG_RST && rc_on_reg)
      else $error("full reset kept registers");
   logic_keep_a: assert property (rst.logic_active && !wr_cfg |=> $stable(cfg_reg))
      else $error("logic reset changed registers");
   full_keep_a: assert property (rst.full_active && !wr_addr |=>
      $stable(addr_reg) && $stable(src_sel_reg))
      else $error("full reset changed address register");
   self_clear_a: assert property (start_full_reg |=> rst.full_active [*2] ##1 !rst.full_active)
      else $error("reset bit did not self clear");
   oe_default_a: assert property (!cfg_reg[OVR_BIT - CFG_LSB] |=> output_enable_o && idle_state_choice_o)
      else $error("default enable or idle state not 1");
   override_a: assert property (cfg_reg[OVR_BIT - CFG_LSB] |=>
      output_enable_o == $past(cfg_reg[3]) && idle_state_choice_o == $past(cfg_reg[0]))
      else $error("override values not applied");
   fallback_a: assert property (cfg_reg[FALLBACK_BIT - CFG_LSB] && !lock_i |=> fallback_clock_sel_o)
      else $error("fallback clock not selected");
   ack_a: assert property (req_i |=> ack_o ##1 !ack_o || $past(req_i))
      else $error("access not answered");

   full_rst_c: cover property (start_full_reg ##3 !rst.full_active);
   logic_rst_c: cover property (start_logic_reg ##1 soft_reset_o);
   remote_clr_c: cover property (wr_rst && remote_i && !wdata_i[RC_ON_BIT] && rc_on_reg);
   fallback_c: cover property (fallback_clock_sel_o && !lock_i);
endmodule

// ===== dsr_host_model.sv
// local or remote host driving one-cycle register accesses into the core registers
// assumes the decoded access port of the register bank on the shared device clock
`timescale 1ns/1ps
module dsr_host_model (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [7:0] rdata_i,
   output logic req_o,
   output logic wr_o,
   output logic remote_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // idle access port from time zero
   initial begin
      req_o = 1'b0;
      wr_o = 1'b0;
      remote_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // one access: a one-cycle request, then a bounded wait for the answer
   task automatic access(input logic w, input logic rem, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 8'h00;
      @(posedge clk_i);
      #1;
      req_o = 1'b1;
      wr_o = w;
      remote_o = rem;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      req_o = 1'b0;
      addr_o = ~a; // released address and data never keep their last value
      wdata_o = ~d;
      for (n = 0; n < 4 && !ok; n++) begin
         if (ack_i === 1'b1) begin
            ok = 1'b1;
            q = rdata_i;
         end else begin
            @(posedge clk_i);
            #1;
         end
      end
   endtask
endmodule

// ===== dsr_pkg.sv
// constants, field positions and state codes of the core control registers
// assumes one 100 MHz device clock shared by every file of the block
package dsr_pkg;
   // register offsets on the access port
   localparam logic [7:0] ADDR_BUS_ADDRESS_SELECT = 8'h00;
   localparam logic [7:0] ADDR_RESET_AND_BACKCHANNEL = 8'h01;
   localparam logic [7:0] ADDR_OUTPUT_OVERRIDE_CONFIG = 8'h02;
   // bus_address_select fields
   localparam int ADDR_SRC_BIT = 0;
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam logic ADDR_SRC_RST = 1'b0;
   // reset_and_backchannel fields
   localparam int RC_ON_BIT = 2;
   localparam int FULL_RST_BIT = 1;
   localparam int LOGIC_RST_BIT = 0;
   localparam logic RC_ON_RST = 1'b1;
   // output_override_config fields, bits 7 to 4 kept in a 4-bit store
   localparam int OE_VAL_BIT = 7;
   localparam int OVR_BIT = 6;
   localparam int FALLBACK_BIT = 5;
   localparam int IDLE_BIT = 4;
   localparam int CFG_LSB = 4;
   localparam logic [3:0] CFG_RST = 4'h0;
   // value shown when the override is off
   localparam logic OVR_DEFAULT = 1'b1;
   localparam logic [7:0] RDATA_NONE = 8'h00;
   // soft reset hold time
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_HOLD_NS = 20;
   localparam int RST_HOLD_CYC_INT = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_HOLD_CYC = 4'(RST_HOLD_CYC_INT);
   // soft reset sequencer states
   typedef enum logic [2:0] {
      DSR_SEQ_IDLE = 3'b001,
      DSR_SEQ_FULL = 3'b010,
      DSR_SEQ_LOGIC = 3'b100
   } dsr_seq_t;
endpackage

// ===== dsr_rst_if.sv
// soft reset request and status lines between register bank and sequencer
// assumes both ends run on the same device clock
`timescale 1ns/1ps
interface dsr_rst_if;
   logic start_full;
   logic start_logic;
   logic full_active;
   logic logic_active;
   modport ctl (output start_full, output start_logic, input full_active, input logic_active);
   modport seq (input start_full, input start_logic, output full_active, output logic_active);
endinterface

// ===== dsr_rst_seq.sv
// soft reset sequencer: holds a full or logic-only reset for a fixed time
// assumes start pulses last one cycle; a start while busy is dropped
`timescale 1ns/1ps
module dsr_rst_seq (
   input wire logic clk_i,
   input wire logic rstn_i,
   dsr_rst_if.seq rst
);
   import dsr_pkg::*;

   dsr_seq_t state_reg;
   dsr_seq_t state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;

   // next state: full reset wins when both are asked at once
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         DSR_SEQ_IDLE: begin
            cnt_next = 4'h0;
            if (rst.start_full) begin
               state_next = DSR_SEQ_FULL;
            end else if (rst.start_logic) begin
               state_next = DSR_SEQ_LOGIC;
            end
         end
         DSR_SEQ_FULL, DSR_SEQ_LOGIC: begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == RST_HOLD_CYC - 4'h1) begin
               state_next = DSR_SEQ_IDLE;
            end
         end
         default: begin
            state_next = DSR_SEQ_IDLE;
            cnt_next = 4'h0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= DSR_SEQ_IDLE;
         cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // active flags decoded from the one-hot state
   assign rst.full_active = (state_reg == DSR_SEQ_FULL);
   assign rst.logic_active = (state_reg == DSR_SEQ_LOGIC);
endmodule

// ===== tb.sv
// self-checking bench for the core control registers with a reference model
// assumes the host model answers within a few cycles and outputs settle two edges after a cause
`timescale 1ns/1ps
module tb;
   import dsr_pkg::*;
   logic clk_i, rstn_i, pass_a, pass_b, lock, req, wr, rem, ack, ok;
   logic rc_act, srst, oe, idle, fb, m_sel, m_rc;
   logic [6:0] strap, own_addr, m_addr, m_strap;
   logic [7:0] addr, wdata, rdata, q, m_cfg, d;
   logic [31:0] seed;
   int err_count, compares;
   dsr_host_model host (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .req_o(req), .wr_o(wr),
      .remote_o(rem), .addr_o(addr), .wdata_o(wdata));
   dsr_core_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .address_strap_pin_i(strap), .req_i(req),
      .wr_i(wr), .remote_i(rem), .addr_i(addr), .wdata_i(wdata), .pass_through_a_i(pass_a),
      .pass_through_b_i(pass_b), .lock_i(lock), .rdata_o(rdata), .ack_o(ack),
      .own_bus_address_o(own_addr), .return_channel_active_o(rc_act), .soft_reset_o(srst),
      .output_enable_o(oe), .idle_state_choice_o(idle), .fallback_clock_sel_o(fb));
   // free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // xorshift random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // model read value of each offset
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00: return {m_addr, m_sel};
         8'h01: return {5'h00, m_rc, 2'b00};
         8'h02: return m_cfg;
         default: return 8'h00;
      endcase
   endfunction
   task automatic complete_run();
      $display("counts: compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dd);
      host.access(w, r, a, dd, q, ok);
      if (ok !== 1'b1) begin
         err_count++;
         complete_run();
      end
   endtask
   // write and mirror into the model
   task automatic wreg(input logic r, input logic [7:0] a, input logic [7:0] dd);
      acc(1'b1, r, a, dd);
      if (a == 8'h00) begin
         m_addr = dd[7:1];
         m_sel = dd[0];
      end
      if (a == 8'h01 && (dd[2] || !r)) m_rc = dd[2];
      if (a == 8'h02) m_cfg = dd & 8'hf0;
      if (a == 8'h01 && dd[1]) begin
         m_rc = 1'b1;
         m_cfg = 8'h00;
      end
   endtask
   task automatic rreg(input logic [7:0] a);
      acc(1'b0, 1'b0, a, 8'h00);
      chk(q, exp_rd(a));
   endtask
   // derived outputs against the model after they settle
   task automatic chk_out();
      repeat (2) @(posedge clk_i);
      #1;
      chk({1'b0, own_addr}, {1'b0, m_sel ? m_addr : m_strap});
      chk({4'h0, rc_act, oe, idle, fb}, {4'h0, m_rc | pass_a | pass_b, m_cfg[6] ? m_cfg[7] : 1'b1,
         m_cfg[6] ? m_cfg[4] : 1'b1, m_cfg[5] & !lock});
   endtask
   // trigger a soft reset and count how long it is held
   task automatic soft_rst(input logic [7:0] dd);
      int n, held;
      wreg(1'b0, 8'h01, dd);
      held = 0;
      for (n = 0; n < 12; n++) begin
         if (srst === 1'b1) held++;
         @(posedge clk_i);
         #1;
      end
      chk(8'(held), 8'(RST_HOLD_CYC_INT));
   endtask
   // main sequence
   initial begin
      err_count = 0;
      compares = 0;
      seed = 32'h1a347375;
      rstn_i = 1'b0;
      pass_a = 1'b0;
      pass_b = 1'b0;
      lock = 1'b1;
      strap = 7'(xs());
      m_addr = strap;
      m_strap = strap;
      m_sel = 1'b0;
      m_rc = 1'b1;
      m_cfg = 8'h00;
      repeat (12) @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      repeat (6) @(posedge clk_i);
      for (int a = 0; a < 3; a++) rreg(8'(a));
      chk_out();
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) begin
         d = {7'(xs()), 1'(i)};
         wreg(1'b0, 8'h00, d);
         rreg(8'h00);
         chk_out();
      end
      $display("test address_select done");
      wreg(1'b1, 8'h01, 8'h00);
      rreg(8'h01);
      wreg(1'b0, 8'h01, 8'h00);
      rreg(8'h01);
      for (int i = 0; i < 4; i++) begin
         pass_a = i[0];
         pass_b = i[1];
         chk_out();
      end
      wreg(1'b1, 8'h01, 8'h04);
      rreg(8'h01);
      $display("test return_channel done");
      for (int i = 0; i < 16; i++) begin
         d = {4'(i), 4'(xs())};
         lock = 1'(xs());
         wreg(1'b0, 8'h02, d);
         rreg(8'h02);
         chk_out();
      end
      $display("test output_override done");
      for (int i = 0; i < 4; i++) begin
         wreg(1'b0, 8'h03 + 8'(xs()) % 8'hfd, 8'(xs()));
         rreg(8'h03 + 8'(xs()) % 8'hfd);
         rreg(8'(i % 3));
      end
      $display("test unmapped done");
      wreg(1'b0, 8'h02, 8'h40);
      wreg(1'b0, 8'h02, 8'hd0);
      soft_rst(8'h05);
      for (int a = 0; a < 3; a++) rreg(8'(a));
      chk_out();
      $display("test logic_reset done");
      wreg(1'b0, 8'h00, {7'(xs()), 1'b1});
      strap = ~strap; // pin moves; only the first capture after power-up counts
      wreg(1'b0, 8'h01, 8'h00);
      wreg(1'b0, 8'h02, 8'he0);
      soft_rst(8'h02);
      for (int a = 0; a < 3; a++) rreg(8'(a));
      chk_out();
      wreg(1'b0, 8'h00, {m_addr, 1'b0});
      chk_out();
      wreg(1'b0, 8'h02, 8'hb0);
      soft_rst(8'h07);
      for (int a = 0; a < 3; a++) rreg(8'(a));
      chk_out();
      $display("test full_reset done");
      complete_run();
   end
endmodule
